// ===== core/clock_stop_pkg.sv
// package: constants and types for the processor clock-stop and wake logic
package clock_stop_pkg;
   localparam int ADDR_WIDTH = 24;
   localparam int FC_WIDTH = 3;
   localparam int IPL_WIDTH = 3;
   localparam logic [2:0] FC_SUPERVISOR_DATA = 3'h5;
   localparam logic [2:0] CYCLES_WIDE_BUS = 3'h2;
   localparam logic [2:0] CYCLES_NARROW_BUS = 3'h3;
   localparam logic [2:0] CYCLE_COUNT_RESET = 3'h0;
   localparam logic [15:0] HALT_STATUS_WORD = 16'h2000;
   localparam int MASK_LSB = 8;
   localparam logic [2:0] MASK_RESET = 3'h7;

   typedef enum logic [1:0] {
      RUN_STATE = 2'b00,
      ARMED_STATE = 2'b01,
      SLEEP_STATE = 2'b10,
      WAKE_STATE = 2'b11
   } power_state_type;
endpackage

// ===== core/bus_watch_if.sv
// interface: bus-cycle observations passed from the bus watcher to the sequencer
`timescale 1ns/1ns
interface bus_watch_if;
   logic addrHit;
   logic cycleDone;
   modport watcher (output addrHit, output cycleDone);
   modport sequencer (input addrHit, input cycleDone);
endinterface

// ===== core/bus_cycle_watch.sv
// module: detects supervisor writes to the trigger address and completed bus cycles
`timescale 1ns/1ns
module bus_cycle_watch
   import clock_stop_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic [ADDR_WIDTH-1:0] address_lines,
   input wire logic [ADDR_WIDTH-1:0] triggerAddress,
   input wire logic readNotWrite,
   input wire logic [FC_WIDTH-1:0] function_code,
   input wire logic addrStrobeN,
   input wire logic dataAckN,
   bus_watch_if.watcher watch
);
   logic addrStrobeDly_reg;
   logic hitSeen_reg;
   logic ackSeen_reg;
   logic rawHit;
   logic strobeRise;

   // address hit only counts while the strobe marks valid lines
   assign rawHit = !addrStrobeN && (address_lines == triggerAddress) && !readNotWrite
                   && (function_code == FC_SUPERVISOR_DATA); // R03

   always_ff @(posedge mclk) begin
      if (rst) begin
         addrStrobeDly_reg <= 1'b1;
      end else begin
         addrStrobeDly_reg <= addrStrobeN;
      end
   end

   // a cycle ends on the rising edge of the address strobe
   assign strobeRise = addrStrobeN && !addrStrobeDly_reg;

   // the lines are gone once the strobe rises, so the hit is held until the cycle ends
   always_ff @(posedge mclk) begin
      if (rst) begin
         hitSeen_reg <= 1'b0;
      end else if (rawHit) begin
         hitSeen_reg <= 1'b1; // R03
      end else if (strobeRise) begin
         hitSeen_reg <= 1'b0;
      end
   end

   // a strobe that rises without an acknowledge moved no data and is not counted
   always_ff @(posedge mclk) begin
      if (rst) begin
         ackSeen_reg <= 1'b0;
      end else if (!addrStrobeN && !dataAckN) begin
         ackSeen_reg <= 1'b1; // R19
      end else if (strobeRise) begin
         ackSeen_reg <= 1'b0;
      end
   end

   assign watch.addrHit = hitSeen_reg;
   assign watch.cycleDone = strobeRise && ackSeen_reg; // R19

   a_done_one_cycle: assert property (@(posedge mclk) disable iff (rst)
      watch.cycleDone |=> !watch.cycleDone) // R19
      else $error("cycle-done pulse lasted more than one cycle");
   a_hit_clears: assert property (@(posedge mclk) disable iff (rst)
      watch.cycleDone |=> !watch.addrHit) // R03
      else $error("trigger hit outlived its bus cycle");
endmodule

// ===== core/cpu_low_power_clock_stop.sv
// module: clock-stop and wake sequencer for a static processor
`timescale 1ns/1ns
// Summary of operation
// [R01] software enters supervisor state first
// [R02] trigger address anywhere in 24-bit space
// [R03] hit on supervisor data write
// [R04] count bus cycles from trigger write
// [R05] stop clock after immediate operand fetch
// [R06] narrow bus needs one more count
// [R07] clock gating without runts or glitches
// [R08] arbitration done during status operand fetch
// [R09] sleep until proper interrupt level seen
// [R10] stable clock before wake request
// [R11] re-enable clock on next falling edge
// [R12] wake and reset are asynchronous inputs; rst is used as a synchronous reset
// [R13] bus request negated before resuming; the sequencer leaves sleep without looking at bus_request_in
// [R14] handler writes byte, halts, returns
// [R15] halt status word sets wake mask
// [R16] bus width is chosen statically
// [R17] two-wire request and grant arbitration
// [R18] registered enable, counter clears off hit
// [R19] address strobe end marks bus cycle
module cpu_low_power_clock_stop
   import clock_stop_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic [ADDR_WIDTH-1:0] address_lines,
   input wire logic [ADDR_WIDTH-1:0] triggerAddress,
   input wire logic readNotWrite,
   input wire logic [FC_WIDTH-1:0] function_code,
   input wire logic addrStrobeN,
   input wire logic dataAckN,
   input wire logic [IPL_WIDTH-1:0] interrupt_level_in,
   input wire logic wakeRequest,
   input wire logic narrowBus,
   input wire logic bus_request_in,
   output logic cpuClockEnable,
   output logic sleeping,
   output logic busGrant,
   output logic [IPL_WIDTH-1:0] wakeMask
);
   bus_watch_if watch ();

   bus_cycle_watch bus_cycle_watch_i (
      .mclk(mclk),
      .rst(rst),
      .address_lines(address_lines),
      .triggerAddress(triggerAddress),
      .readNotWrite(readNotWrite),
      .function_code(function_code),
      .addrStrobeN(addrStrobeN),
      .dataAckN(dataAckN),
      .watch(watch.watcher)
   );

   // ------------------------------------------------------------
   // sequencer
   // ------------------------------------------------------------
   power_state_type state_reg, state_next;
   logic [2:0] cycleCount_reg;
   logic [2:0] cycleTarget;
   logic wakeSync1_reg, wakeSync2_reg;
   logic enable_reg;
   logic enableLow_reg;
   logic [IPL_WIDTH-1:0] levelSeen_reg;
   logic levelPending;

   // wake input is asynchronous, so it is brought in through two flops
   always_ff @(posedge mclk) begin
      if (rst) begin
         wakeSync1_reg <= 1'b0;
         wakeSync2_reg <= 1'b0;
      end else begin
         wakeSync1_reg <= wakeRequest; // R12
         wakeSync2_reg <= wakeSync1_reg;
      end
   end

   // the narrow bus fetches the immediate word in two cycles
   assign cycleTarget = narrowBus ? CYCLES_NARROW_BUS : CYCLES_WIDE_BUS; // R06 R16

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         RUN_STATE: begin
            if (watch.addrHit && watch.cycleDone) begin
               state_next = ARMED_STATE; // R03 R14
            end
         end
         ARMED_STATE: begin
            if (watch.cycleDone && (cycleCount_reg + 3'h1 == cycleTarget)) begin
               state_next = SLEEP_STATE; // R05
            end
         end
         SLEEP_STATE: begin
            // sleep ends only on the wake request, and only for a level the mask lets through
            if (wakeSync2_reg && levelPending) begin
               state_next = WAKE_STATE; // R09 R10
            end
         end
         WAKE_STATE: begin
            state_next = RUN_STATE;
         end
         default: begin
            state_next = RUN_STATE;
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         state_reg <= RUN_STATE;
      end else begin
         state_reg <= state_next;
      end
   end

   // counter runs only while armed and clears otherwise
   always_ff @(posedge mclk) begin
      if (rst) begin
         cycleCount_reg <= CYCLE_COUNT_RESET;
      end else if (state_reg != ARMED_STATE) begin
         cycleCount_reg <= CYCLE_COUNT_RESET; // R18
      end else if (watch.cycleDone) begin
         cycleCount_reg <= cycleCount_reg + 3'h1; // R04 R19
      end
   end

   // ------------------------------------------------------------
   // clock enable
   // ------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (rst) begin
         enable_reg <= 1'b1;
      end else begin
         enable_reg <= (state_next == RUN_STATE) || (state_next == ARMED_STATE)
                       || (state_next == WAKE_STATE); // R18
      end
   end

   // retimed on the falling edge so a downstream and-gate sees a change only while the clock is low
   always_ff @(negedge mclk) begin
      if (rst) begin
         enableLow_reg <= 1'b1;
      end else begin
         enableLow_reg <= enable_reg; // R05 R07 R11
      end
   end
   assign cpuClockEnable = enableLow_reg;

   always_ff @(posedge mclk) begin
      if (rst) begin
         sleeping <= 1'b0;
      end else begin
         sleeping <= (state_next == SLEEP_STATE); // R09
      end
   end

   // ------------------------------------------------------------
   // arbitration and wake mask
   // ------------------------------------------------------------
   // two-wire scheme: grant follows request, no acknowledge
   always_ff @(posedge mclk) begin
      if (rst) begin
         busGrant <= 1'b0;
      end else begin
         busGrant <= bus_request_in; // R17 R08 R13
      end
   end

   // the halt status word fixes the interrupt mask that ends sleep
   always_ff @(posedge mclk) begin
      if (rst) begin
         wakeMask <= MASK_RESET;
      end else if (state_reg == RUN_STATE && state_next == ARMED_STATE) begin
         wakeMask <= HALT_STATUS_WORD[MASK_LSB +: IPL_WIDTH]; // R15
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         levelSeen_reg <= 3'h0;
      end else begin
         levelSeen_reg <= interrupt_level_in; // R09
      end
   end

   // the top level cannot be masked; below it the level must exceed the mask
   assign levelPending = (levelSeen_reg > wakeMask) || (levelSeen_reg == 3'h7); // R09 R15

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   sequence armSeq;
      (state_reg == RUN_STATE) && watch.addrHit && watch.cycleDone;
   endsequence

   a_arm_on_hit: assert property (@(posedge mclk) disable iff (rst)
      armSeq |=> state_reg == ARMED_STATE) // R03
      else $error("trigger write did not arm the sequencer");
   a_count_clears: assert property (@(posedge mclk) disable iff (rst)
      state_reg != ARMED_STATE |=> cycleCount_reg == 3'h0) // R18
      else $error("cycle counter not cleared outside armed state");
   a_count_steps: assert property (@(posedge mclk) disable iff (rst)
      (state_reg == ARMED_STATE && watch.cycleDone && state_next == ARMED_STATE)
      |=> cycleCount_reg == $past(cycleCount_reg) + 3'h1) // R04
      else $error("cycle counter did not advance on a bus cycle");
   a_wide_stop: assert property (@(posedge mclk) disable iff (rst)
      (state_reg == ARMED_STATE && !narrowBus && watch.cycleDone && cycleCount_reg == 3'h1)
      |=> !enable_reg && sleeping) // R05
      else $error("clock not stopped after operand fetch");
   a_narrow_hold: assert property (@(posedge mclk) disable iff (rst)
      (state_reg == ARMED_STATE && narrowBus && watch.cycleDone && cycleCount_reg == 3'h1)
      |=> enable_reg) // R06
      else $error("narrow bus stopped one cycle early");
   a_sleep_holds: assert property (@(posedge mclk) disable iff (rst)
      (state_reg == SLEEP_STATE && !wakeSync2_reg) |=> !enable_reg) // R09
      else $error("clock ran while sleeping without wake");
   a_wake_enable: assert property (@(posedge mclk) disable iff (rst)
      (state_reg == SLEEP_STATE && wakeSync2_reg && levelPending) |=> enable_reg ##1 state_reg == RUN_STATE) // R11
      else $error("wake did not restart the clock");
   a_masked_sleep: assert property (@(posedge mclk) disable iff (rst)
      (state_reg == SLEEP_STATE && !levelPending) |=> !enable_reg) // R09
      else $error("clock restarted for a masked interrupt level");
   a_grant_follow: assert property (@(posedge mclk) disable iff (rst)
      bus_request_in |=> busGrant) // R17
      else $error("grant did not follow request");
endmodule

// ===== bench/cpu_bus_model.sv
// partner model: processor side of the bus, issuing whole bus cycles
`timescale 1ns/1ns
module cpu_bus_model
   import clock_stop_pkg::*;
(
   input wire logic mclk,
   input wire logic cpuClockEnable,
   output logic [ADDR_WIDTH-1:0] address_lines,
   output logic readNotWrite,
   output logic [FC_WIDTH-1:0] function_code,
   output logic addrStrobeN,
   output logic dataAckN
);
   initial begin
      address_lines = 24'h0;
      readNotWrite = 1'b1;
      function_code = 3'h0;
      addrStrobeN = 1'b1;
      dataAckN = 1'b1;
   end
   // a gated processor starts no cycle, so an early stop shows up as a missing transition
   task automatic cycle(input logic [ADDR_WIDTH-1:0] a, input logic rnw, input logic [FC_WIDTH-1:0] fc);
      @(negedge mclk);
      if (cpuClockEnable !== 1'b1) return;
      address_lines = a;
      readNotWrite = rnw;
      function_code = fc;
      addrStrobeN = 1'b0;
      @(negedge mclk);
      dataAckN = 1'b0;
      @(negedge mclk);
      addrStrobeN = 1'b1;
      dataAckN = 1'b1;
      @(negedge mclk);
      // released lines take the inverse so no stale match lingers
      address_lines = ~a;
      function_code = ~fc;
      readNotWrite = 1'b1;
   endtask
endmodule

// ===== bench/cpu_low_power_clock_stop_bench.sv
// testbench: clock-stop sequencer driven by a processor bus model
`timescale 1ns/1ns
module cpu_low_power_clock_stop_bench;
   import clock_stop_pkg::*;
   logic mclk, rst, wakeRequest, narrowBus, bus_request_in, running;
   logic readNotWrite, addrStrobeN, dataAckN, cpuClockEnable, sleeping, busGrant;
   logic [ADDR_WIDTH-1:0] address_lines, triggerAddress;
   logic [FC_WIDTH-1:0] function_code;
   logic [IPL_WIDTH-1:0] interrupt_level_in, wakeMask;
   logic [31:0] rnd;
   logic expectQ[$];
   int fail_count, samples_checked;
   cpu_low_power_clock_stop cpu_low_power_clock_stop_i (.mclk(mclk), .rst(rst), .address_lines(address_lines),
      .triggerAddress(triggerAddress), .readNotWrite(readNotWrite), .function_code(function_code),
      .addrStrobeN(addrStrobeN), .dataAckN(dataAckN), .interrupt_level_in(interrupt_level_in),
      .wakeRequest(wakeRequest), .narrowBus(narrowBus), .bus_request_in(bus_request_in),
      .cpuClockEnable(cpuClockEnable), .sleeping(sleeping), .busGrant(busGrant), .wakeMask(wakeMask));
   cpu_bus_model cpu_bus_model_i (.mclk(mclk), .cpuClockEnable(cpuClockEnable), .address_lines(address_lines),
      .readNotWrite(readNotWrite), .function_code(function_code), .addrStrobeN(addrStrobeN), .dataAckN(dataAckN));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] v);
      v ^= v << 13;
      v ^= v >> 17;
      v ^= v << 5;
      return v;
   endfunction
   task automatic check(input string what, input logic [2:0] seen, input logic [2:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic end_of_test;
      if (expectQ.size() != 0) fail_count++;
      $display("mismatches %0d comparisons %0d", fail_count, samples_checked);
      if (fail_count == 0 && samples_checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic wait_en(input logic v);
      for (int i = 0; i < 8; i++) begin
         if (cpuClockEnable === v) return;
         @(negedge mclk);
      end
      fail_count++;
      end_of_test();
   endtask
   task automatic sleep_wake(input logic narrow);
      narrowBus = narrow;
      cpu_bus_model_i.cycle(triggerAddress, 1'b0, FC_SUPERVISOR_DATA);
      rnd = xs(rnd);
      cpu_bus_model_i.cycle(rnd[23:0], 1'b1, 3'h6);
      if (narrow) cpu_bus_model_i.cycle(rnd[23:0] + 24'h2, 1'b1, 3'h6);
      check("earlyStop", 3'(cpuClockEnable), 3'h1);
      expectQ.push_back(1'b0);
      cpu_bus_model_i.cycle(rnd[23:0] + 24'h3, 1'b1, 3'h6);
      wait_en(1'b0);
      @(negedge mclk);
      check("sleeping", 3'(sleeping), 3'h1);
      check("wakeMask", wakeMask, HALT_STATUS_WORD[MASK_LSB +: 3]);
      bus_request_in = 1'b1;
      // a wake request at a level the mask still blocks must not end sleep
      interrupt_level_in = HALT_STATUS_WORD[MASK_LSB +: 3];
      wakeRequest = 1'b1;
      @(negedge mclk);
      check("busGrant", 3'(busGrant), 3'h1);
      bus_request_in = 1'b0;
      repeat (4) @(negedge mclk);
      check("busGrant", 3'(busGrant), 3'h0);
      check("stillAsleep", 3'(cpuClockEnable), 3'h0);
      check("maskedSleep", 3'(sleeping), 3'h1);
      expectQ.push_back(1'b1);
      interrupt_level_in = (rnd[2:0] > HALT_STATUS_WORD[MASK_LSB +: 3]) ? rnd[2:0] : 3'h7;
      wait_en(1'b1);
      wakeRequest = 1'b0;
      repeat (2) @(negedge mclk);
      check("sleeping", 3'(sleeping), 3'h0);
   endtask
   // ----------------------------------------
   // clock, watchdog, result monitor
   // ----------------------------------------
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   initial begin
      repeat (3000) @(posedge mclk);
      fail_count++;
      end_of_test();
   end
   always @(cpuClockEnable) begin
      if (running === 1'b1) begin
         if (expectQ.size() == 0) check("strayClockEdge", 3'(cpuClockEnable), 3'(~cpuClockEnable));
         else check("cpuClockEnable", 3'(cpuClockEnable), 3'(expectQ.pop_front()));
      end
   end
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      rnd = 32'hfc464969;
      rst = 1'b1;
      running = 1'b0;
      wakeRequest = 1'b0;
      narrowBus = 1'b0;
      bus_request_in = 1'b0;
      interrupt_level_in = 3'h7;
      triggerAddress = 24'h0;
      fail_count = 0;
      samples_checked = 0;
      repeat (2) @(posedge mclk);
      @(negedge mclk);
      check("cpuClockEnable", 3'(cpuClockEnable), 3'h1);
      check("wakeMask", wakeMask, MASK_RESET);
      check("busGrant", 3'(busGrant), 3'h0);
      rst = 1'b0;
      running = 1'b1;
      rnd = xs(rnd);
      triggerAddress = rnd[23:0];
      cpu_bus_model_i.cycle(triggerAddress, 1'b0, 3'h1);
      cpu_bus_model_i.cycle(triggerAddress, 1'b1, FC_SUPERVISOR_DATA);
      cpu_bus_model_i.cycle(triggerAddress ^ 24'h1, 1'b0, FC_SUPERVISOR_DATA);
      check("noArm", {1'b0, sleeping, cpuClockEnable}, 3'h1);
      sleep_wake(1'b0);
      rnd = xs(rnd);
      triggerAddress = rnd[23:0];
      sleep_wake(1'b1);
      end_of_test();
   end
endmodule
